// ---- tcwu_drv_model.sv ----
`timescale 1ns/1ps
module tcwu_drv_model (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         srst_i,
	// Pins from the unit
	input  wire logic [tcwu_pkg::PIN_W-1:0]   pin_i,
	input  wire logic [tcwu_pkg::PIN_W-1:0]   ovr_i,
	// Fault request from the bench
	input  wire logic                         trip_i,
	// Event channel and driver health
	output logic                              fault_evt_o,
	output int                                shoot_cnt_o
);
	// Event channel forwards the trip with no delay
	assign fault_evt_o = trip_i;

	// Count cycles where a bridge leg has both switches on
	// A real half-bridge would short here, so any count is fatal
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			shoot_cnt_o <= 0;
		end else if (|(ovr_i & pin_i & (pin_i >> 1) & tcwu_pkg::PAIR_MASK)) begin
			shoot_cnt_o <= shoot_cnt_o + 1;
		end
	end
endmodule

// ---- tcwu_pkg.sv ----
package tcwu_pkg;
	localparam int CNT_W  = 16;
	localparam int HALF_W = 8;
	localparam int NCH    = 4;
	localparam int NCH_T1 = 2;
	localparam int DT_W   = 8;
	localparam int PIN_W  = 8;
	localparam int PRE_W  = 10;
	localparam int NF_W   = 4;
	localparam int HR4_SH = 2;
	localparam int HR8_SH = 3;
	localparam logic [CNT_W-1:0] PER_RST   = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
	localparam logic [DT_W-1:0]  DT_RST    = 8'h00;
	localparam logic [PIN_W-1:0] PAIR_MASK = 8'h55;
	localparam logic [1:0]       HR_X4     = 2'h1;
	localparam logic [1:0]       HR_X8     = 2'h2;

	typedef enum logic [2:0] {CS_OFF = 3'b001, CS_PER = 3'b010, CS_EVT = 3'b100} tcwu_clk_e;
	typedef enum logic [2:0] {WG_FRQ = 3'b001, WG_SS = 3'b010, WG_DS = 3'b100} tcwu_wg_e;
	typedef enum logic [2:0] {CP_IN = 3'b001, CP_FRQ = 3'b010, CP_PW = 3'b100} tcwu_cap_e;
	typedef enum logic [1:0] {FS_RUN = 2'b01, FS_FLT = 2'b10} tcwu_flt_e;

	typedef struct packed {
		tcwu_clk_e  clk_sel;
		logic [3:0] presc;
		logic       dir_down;
		tcwu_wg_e   wg_mode;
		logic       capture_en;
		tcwu_cap_e  cap_mode;
		logic       split;
		logic [1:0] hires;
	} tcwu_cfg_s;

	typedef struct packed {
		logic             dti_en;
		logic             pg_en;
		logic             pg_cha;
		logic             halt_en;
		logic [PIN_W-1:0] ovr_mask;
	} tcwu_advanced_waveform_extension_s;

	typedef struct packed {
		logic [PIN_W-1:0] mask;
		logic [PIN_W-1:0] value;
	} tcwu_pat_s;
endpackage

// ---- tcwu_top.sv ----
`timescale 1ns/1ps
module tcwu_top #(
	parameter bit TYPE1 = 1'b0
) (
	// Clock and reset
	input  wire logic                                clk_i,
	input  wire logic                                srst_i,
	// Configuration
	input  wire tcwu_pkg::tcwu_cfg_s                 cfg_i,
	input  wire tcwu_pkg::tcwu_advanced_waveform_extension_s                advanced_waveform_extension_i,
	// Buffered writes
	input  wire logic                                per_wr_i,
	input  wire logic [tcwu_pkg::CNT_W-1:0]          per_val_i,
	input  wire logic [tcwu_pkg::NCH-1:0]            cc_wr_i,
	input  wire logic [tcwu_pkg::CNT_W-1:0]          cc_val_i,
	input  wire logic                                dt_wr_i,
	input  wire logic [tcwu_pkg::DT_W-1:0]           dt_ls_i,
	input  wire logic [tcwu_pkg::DT_W-1:0]           dt_hs_i,
	input  wire logic                                pat_wr_i,
	input  wire tcwu_pkg::tcwu_pat_s                 pat_i,
	// Events and capture inputs
	input  wire logic                                cnt_evt_i,
	input  wire logic [tcwu_pkg::NCH-1:0]            cap_in_i,
	input  wire logic [tcwu_pkg::NCH-1:0]            cap_ack_i,
	input  wire logic                                fault_evt_i,
	input  wire logic                                fault_clr_i,
	// Status and waveforms
	output logic [tcwu_pkg::CNT_W-1:0]               cnt_o,
	output logic [tcwu_pkg::NCH-1:0][tcwu_pkg::CNT_W-1:0] ch_val_o,
	output logic                                     ovf_o,
	output logic                                     hunf_o,
	output logic                                     err_o,
	output logic [tcwu_pkg::NCH-1:0]                 cc_irq_o,
	output logic [2*tcwu_pkg::NCH-1:0]               wg_o,
	output logic [tcwu_pkg::PIN_W-1:0]               pin_o,
	output logic [tcwu_pkg::PIN_W-1:0]               pin_ovr_o,
	output logic                                     fault_o,
	output logic [2:0]                               hires_frac_o
);
	localparam int CW = tcwu_pkg::CNT_W;
	localparam int HW = tcwu_pkg::HALF_W;
	localparam int N  = tcwu_pkg::NCH;

	// Compare value seen by the counter; channel 0 hi-res fraction bits go to the fast stage
	function automatic logic [CW-1:0] cmp_val(input logic [CW-1:0] cc, input logic [1:0] hr);
		if (hr == tcwu_pkg::HR_X4)
			cmp_val = cc >> tcwu_pkg::HR4_SH;
		else if (hr == tcwu_pkg::HR_X8)
			cmp_val = cc >> tcwu_pkg::HR8_SH;
		else
			cmp_val = cc;
	endfunction

	logic [tcwu_pkg::PRE_W-1:0] pre_reg, pre_next, pmask;
	logic [CW-1:0] cnt_reg, cnt_next, top, per_act_reg;
	logic up_reg, up_next, ovf_next, hunf_next, tick, upd, halt, restart, split;
	logic [N-1:0] ch_ok, cap_hit, cmp_hit;

	// Type 1 and split restrictions
	always_comb begin
		for (int i = 0; i < N; i++)
			ch_ok[i] = !(TYPE1 && i >= tcwu_pkg::NCH_T1);
		split = cfg_i.split && !TYPE1;
	end

	// Prescaler and base counter
	always_comb begin
		pre_next = pre_reg + 1'b1;
		pmask = ~({tcwu_pkg::PRE_W{1'b1}} << cfg_i.presc);
		tick = ((cfg_i.clk_sel == tcwu_pkg::CS_PER) && ((pre_reg & pmask) == pmask))
			|| ((cfg_i.clk_sel == tcwu_pkg::CS_EVT) && cnt_evt_i);
		tick = tick && !halt;
		top = (cfg_i.wg_mode == tcwu_pkg::WG_FRQ && !cfg_i.capture_en)
			? cmp_val(ch_val_o[0], cfg_i.hires) : per_act_reg;
		cnt_next = cnt_reg;
		up_next = up_reg;
		ovf_next = 1'b0;
		hunf_next = 1'b0;
		if (split) begin
			if (tick) begin
				if (cnt_reg[HW-1:0] == '0) begin
					cnt_next[HW-1:0] = per_act_reg[HW-1:0];
					ovf_next = 1'b1;
				end else
					cnt_next[HW-1:0] = cnt_reg[HW-1:0] - 1'b1;
				if (cnt_reg[CW-1:HW] == '0) begin
					cnt_next[CW-1:HW] = per_act_reg[CW-1:HW];
					hunf_next = 1'b1;
				end else
					cnt_next[CW-1:HW] = cnt_reg[CW-1:HW] - 1'b1;
			end
		end else if (restart)
			cnt_next = tcwu_pkg::CNT_RST;
		else if (tick) begin
			if (cfg_i.wg_mode == tcwu_pkg::WG_DS && !cfg_i.capture_en) begin
				if (up_reg) begin
					if (cnt_reg >= top) begin
						up_next = 1'b0;
						cnt_next = cnt_reg - 1'b1;
					end else
						cnt_next = cnt_reg + 1'b1;
				end else if (cnt_reg == '0) begin
					up_next = 1'b1;
					ovf_next = 1'b1;
					cnt_next = cnt_reg + 1'b1;
				end else
					cnt_next = cnt_reg - 1'b1;
			end else if (cfg_i.dir_down) begin
				if (cnt_reg == '0) begin
					cnt_next = top;
					ovf_next = 1'b1;
				end else
					cnt_next = cnt_reg - 1'b1;
			end else if (cnt_reg >= top) begin
				cnt_next = tcwu_pkg::CNT_RST;
				ovf_next = 1'b1;
			end else
				cnt_next = cnt_reg + 1'b1;
		end
		upd = ovf_next;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_reg <= '0;
			cnt_reg <= tcwu_pkg::CNT_RST;
			up_reg  <= 1'b1;
			ovf_o   <= 1'b0;
			hunf_o  <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			up_reg  <= up_next;
			ovf_o   <= ovf_next;
			hunf_o  <= hunf_next;
		end
	end
	assign cnt_o = cnt_reg;

	// Noise filter on capture inputs; a level must hold for the whole window
	logic [N-1:0][tcwu_pkg::NF_W-1:0] filt_reg, filt_next;
	logic [N-1:0] lvl_reg, lvl_next, rise, fall;
	always_comb begin
		restart = 1'b0;
		cap_hit = '0;
		for (int i = 0; i < N; i++) begin
			filt_next[i] = {filt_reg[i][tcwu_pkg::NF_W-2:0], cap_in_i[i]};
			lvl_next[i] = (&filt_reg[i]) ? 1'b1 : (|filt_reg[i]) ? lvl_reg[i] : 1'b0;
			rise[i] = lvl_next[i] && !lvl_reg[i];
			fall[i] = !lvl_next[i] && lvl_reg[i];
		end
		if (cfg_i.capture_en && !split) begin
			case (cfg_i.cap_mode)
				tcwu_pkg::CP_FRQ: begin
					cap_hit[0] = rise[0];
					restart = rise[0];
				end
				tcwu_pkg::CP_PW: begin
					cap_hit[0] = fall[0];
					restart = rise[0];
				end
				default: cap_hit = rise & ch_ok;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			filt_reg <= '0;
			lvl_reg  <= '0;
		end else begin
			filt_reg <= filt_next;
			lvl_reg  <= lvl_next;
		end
	end

	// Period and channel buffers, capture store and channel requests
	logic [CW-1:0] per_act_next, per_buf_reg, per_buf_next;
	logic per_bv_reg, per_bv_next, err_next;
	logic [N-1:0][CW-1:0] cc_buf_reg, cc_buf_next, cc_act_next;
	logic [N-1:0] cc_bv_reg, cc_bv_next, full_reg, full_next;
	always_comb begin
		per_buf_next = per_wr_i ? per_val_i : per_buf_reg;
		per_bv_next = per_wr_i || (per_bv_reg && !upd);
		per_act_next = (upd && per_bv_reg) ? per_buf_reg : per_act_reg;
		err_next = 1'b0;
		for (int i = 0; i < N; i++) begin
			cc_buf_next[i] = cc_wr_i[i] ? cc_val_i : cc_buf_reg[i];
			cc_bv_next[i] = (cc_wr_i[i] && ch_ok[i]) || (cc_bv_reg[i] && !upd);
			cc_act_next[i] = (upd && cc_bv_reg[i]) ? cc_buf_reg[i] : ch_val_o[i];
			if (cap_hit[i])
				cc_act_next[i] = cnt_reg;
			full_next[i] = cap_hit[i] || (full_reg[i] && !cap_ack_i[i]);
			err_next = err_next || (cap_hit[i] && full_reg[i] && !cap_ack_i[i]);
			if (split)
				cmp_hit[i] = tick && cnt_reg[HW-1:0] == ch_val_o[i][HW-1:0];
			else
				cmp_hit[i] = tick && cnt_reg == cmp_val(ch_val_o[i], cfg_i.hires);
			cmp_hit[i] = cmp_hit[i] && ch_ok[i] && !cfg_i.capture_en;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			per_act_reg <= tcwu_pkg::PER_RST;
			per_buf_reg <= tcwu_pkg::PER_RST;
			per_bv_reg  <= 1'b0;
			cc_buf_reg  <= '0;
			cc_bv_reg   <= '0;
			ch_val_o    <= '0;
			full_reg    <= '0;
			err_o       <= 1'b0;
			cc_irq_o    <= '0;
		end else begin
			per_act_reg <= per_act_next;
			per_buf_reg <= per_buf_next;
			per_bv_reg  <= per_bv_next;
			cc_buf_reg  <= cc_buf_next;
			cc_bv_reg   <= cc_bv_next;
			ch_val_o    <= cc_act_next;
			full_reg    <= full_next;
			err_o       <= err_next;
			cc_irq_o    <= cmp_hit | cap_hit;
		end
	end

	// Waveform generation and hi-res fraction
	logic [2*N-1:0] wg_next;
	logic [2:0] frac_next;
	always_comb begin
		wg_next = '0;
		for (int i = 0; i < N; i++) begin
			if (split) begin
				wg_next[i] = cnt_reg[HW-1:0] < ch_val_o[i][HW-1:0];
				wg_next[i+N] = cnt_reg[CW-1:HW] < ch_val_o[i][CW-1:HW];
			end else if (!cfg_i.capture_en && ch_ok[i]) begin
				if (cfg_i.wg_mode == tcwu_pkg::WG_FRQ)
					wg_next[i] = (i == 0) ? (wg_o[0] ^ ovf_next) : 1'b0;
				else
					wg_next[i] = cnt_reg < cmp_val(ch_val_o[i], cfg_i.hires);
			end
		end
		// Fraction drives the fast-clock phase stage outside this domain
		if (cfg_i.hires == tcwu_pkg::HR_X4)
			frac_next = {1'b0, ch_val_o[0][tcwu_pkg::HR4_SH-1:0]};
		else if (cfg_i.hires == tcwu_pkg::HR_X8)
			frac_next = ch_val_o[0][tcwu_pkg::HR8_SH-1:0];
		else
			frac_next = '0;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wg_o         <= '0;
			hires_frac_o <= '0;
		end else begin
			wg_o         <= wg_next;
			hires_frac_o <= frac_next;
		end
	end

	// Dead-time inserters; both sides held low while a gap counts down
	logic [tcwu_pkg::DT_W-1:0] dls_act_reg, dls_act_next, dhs_act_reg, dhs_act_next;
	logic [tcwu_pkg::DT_W-1:0] dls_buf_reg, dls_buf_next, dhs_buf_reg, dhs_buf_next;
	logic dt_bv_reg, dt_bv_next;
	logic [N-1:0][tcwu_pkg::DT_W-1:0] dcnt_reg, dcnt_next;
	logic [N-1:0] wprev_reg, ls_reg, ls_next, hs_reg, hs_next;
	always_comb begin
		dls_buf_next = dt_wr_i ? dt_ls_i : dls_buf_reg;
		dhs_buf_next = dt_wr_i ? dt_hs_i : dhs_buf_reg;
		dt_bv_next = dt_wr_i || (dt_bv_reg && !upd);
		dls_act_next = (upd && dt_bv_reg) ? dls_buf_reg : dls_act_reg;
		dhs_act_next = (upd && dt_bv_reg) ? dhs_buf_reg : dhs_act_reg;
		halt = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (wg_o[i] != wprev_reg[i])
				dcnt_next[i] = wg_o[i] ? dls_act_reg : dhs_act_reg;
			else if (dcnt_reg[i] != '0)
				dcnt_next[i] = dcnt_reg[i] - 1'b1;
			else
				dcnt_next[i] = dcnt_reg[i];
			ls_next[i] = wg_o[i] && dcnt_next[i] == '0;
			hs_next[i] = !wg_o[i] && dcnt_next[i] == '0;
			halt = halt || (dcnt_reg[i] != '0);
		end
		halt = halt && advanced_waveform_extension_i.halt_en && advanced_waveform_extension_i.dti_en && !TYPE1;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dls_act_reg <= tcwu_pkg::DT_RST;
			dhs_act_reg <= tcwu_pkg::DT_RST;
			dls_buf_reg <= tcwu_pkg::DT_RST;
			dhs_buf_reg <= tcwu_pkg::DT_RST;
			dt_bv_reg   <= 1'b0;
			dcnt_reg    <= '0;
			wprev_reg   <= '0;
			ls_reg      <= '0;
			hs_reg      <= '0;
		end else begin
			dls_act_reg <= dls_act_next;
			dhs_act_reg <= dhs_act_next;
			dls_buf_reg <= dls_buf_next;
			dhs_buf_reg <= dhs_buf_next;
			dt_bv_reg   <= dt_bv_next;
			dcnt_reg    <= dcnt_next;
			wprev_reg   <= wg_o[N-1:0];
			ls_reg      <= ls_next;
			hs_reg      <= hs_next;
		end
	end

	// Pattern buffer, fault state and port override
	tcwu_pkg::tcwu_pat_s pat_act_reg, pat_act_next, pat_buf_reg, pat_buf_next;
	tcwu_pkg::tcwu_flt_e flt_reg, flt_next;
	logic pat_bv_reg, pat_bv_next, advanced_waveform_extension_on;
	logic [tcwu_pkg::PIN_W-1:0] pv, ovr, pin_next, ovr_next;
	always_comb begin
		pat_buf_next = pat_wr_i ? pat_i : pat_buf_reg;
		pat_bv_next = pat_wr_i || (pat_bv_reg && !upd);
		pat_act_next = (upd && pat_bv_reg) ? pat_buf_reg : pat_act_reg;
		advanced_waveform_extension_on = !TYPE1 && (advanced_waveform_extension_i.dti_en || advanced_waveform_extension_i.pg_en);
		flt_next = flt_reg;
		case (flt_reg)
			tcwu_pkg::FS_RUN:
				if (fault_evt_i)
					flt_next = tcwu_pkg::FS_FLT;
			tcwu_pkg::FS_FLT:
				if (fault_clr_i && !fault_evt_i)
					flt_next = tcwu_pkg::FS_RUN;
			default: flt_next = tcwu_pkg::FS_FLT;
		endcase
		for (int i = 0; i < N; i++) begin
			pv[2*i] = ls_reg[i];
			pv[2*i+1] = hs_reg[i];
		end
		if (advanced_waveform_extension_i.pg_en) begin
			pv = advanced_waveform_extension_i.pg_cha ? {tcwu_pkg::PIN_W{wg_o[0]}} : pat_act_reg.value;
			ovr = pat_act_reg.mask;
		end else
			ovr = advanced_waveform_extension_i.ovr_mask;
		ovr_next = advanced_waveform_extension_on ? ovr : '0;
		pin_next = (flt_next == tcwu_pkg::FS_FLT) ? '0 : (pv & ovr_next);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pat_act_reg <= '0;
			pat_buf_reg <= '0;
			pat_bv_reg  <= 1'b0;
			flt_reg     <= tcwu_pkg::FS_RUN;
			pin_o       <= '0;
			pin_ovr_o   <= '0;
			fault_o     <= 1'b0;
		end else begin
			pat_act_reg <= pat_act_next;
			pat_buf_reg <= pat_buf_next;
			pat_bv_reg  <= pat_bv_next;
			flt_reg     <= flt_next;
			pin_o       <= pin_next;
			pin_ovr_o   <= ovr_next;
			fault_o     <= flt_next == tcwu_pkg::FS_FLT;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	split_down_a: assert property (split && tick && cnt_reg[HW-1:0] != '0
		|=> cnt_reg[HW-1:0] == $past(cnt_reg[HW-1:0]) - 1'b1) else $error("split count not down");
	fault_off_a: assert property (fault_evt_i |=> pin_o == '0 && fault_o)
		else $error("fault did not clear pins");
	fault_hold_a: assert property (fault_o && !fault_clr_i |=> fault_o [*1] ##0 pin_o == '0)
		else $error("fault released without clear");
	ovf_wrap_a: assert property (ovf_next && !split && !cfg_i.dir_down
		&& cfg_i.wg_mode == tcwu_pkg::WG_SS |=> cnt_o == '0 && ovf_o) else $error("bad wrap");
	per_buf_a: assert property (!upd |=> $stable(per_act_reg))
		else $error("period changed off update");
	cap_mode_a: assert property (cfg_i.capture_en |-> cmp_hit == '0)
		else $error("compare hit in capture mode");
	type1_ch_a: assert property (TYPE1 |-> ##1 cc_irq_o[N-1:tcwu_pkg::NCH_T1] == '0)
		else $error("missing channel active");
	dti_pair_a: assert property (!$past(advanced_waveform_extension_i.pg_en)
		|-> (pin_o & (pin_o >> 1) & tcwu_pkg::PAIR_MASK) == '0) else $error("sides overlap");
	split_hirq_a: assert property (split && tick && ch_val_o[0][HW-1:0] != cnt_reg[HW-1:0]
		|=> !cc_irq_o[0]) else $error("high counter raised match");

	split_uf_c: cover property (split && ovf_o ##[1:20] hunf_o);
	fault_c: cover property (fault_o ##1 fault_clr_i ##1 !fault_o);
	cap_err_c: cover property (err_o);
	dti_gap_c: cover property (dcnt_reg[0] != '0 && halt);
endmodule

// ---- test_timer_counter_waveform_unit.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module test_timer_counter_waveform_unit;
	logic                                            clk_i, srst_i;
	tcwu_pkg::tcwu_cfg_s                             cfg_i;
	tcwu_pkg::tcwu_advanced_waveform_extension_s                            advanced_waveform_extension_i;
	logic                                            per_wr_i, dt_wr_i, pat_wr_i;
	logic [15:0]                                     per_val_i, cc_val_i;
	logic [3:0]                                      cc_wr_i, cc_irq_o;
	logic [7:0]                                      dt_ls_i, dt_hs_i, pin_o, pin_ovr_o, seen;
	tcwu_pkg::tcwu_pat_s                             pat_i;
	logic                                            cnt_evt_i, fault_evt, fault_clr_i, trip;
	logic [15:0]                                     cnt_o, c0;
	logic [3:0][15:0]                                ch_val_o;
	logic                                            ovf_o, hunf_o, err_o, fault_o;
	logic [7:0]                                      wg_o;
	logic [2:0]                                      hires_frac_o;
	logic [3:0][15:0]                                cmp;
	int                                              bad_count, compares, shoot, i, k, n;
	int                                              seed = 32'h8351c686;

	tcwu_top dut (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg_i), .advanced_waveform_extension_i(advanced_waveform_extension_i),
		.per_wr_i(per_wr_i), .per_val_i(per_val_i), .cc_wr_i(cc_wr_i), .cc_val_i(cc_val_i),
		.dt_wr_i(dt_wr_i), .dt_ls_i(dt_ls_i), .dt_hs_i(dt_hs_i), .pat_wr_i(pat_wr_i),
		.pat_i(pat_i), .cnt_evt_i(cnt_evt_i), .cap_in_i(4'h0), .cap_ack_i(4'h0),
		.fault_evt_i(fault_evt), .fault_clr_i(fault_clr_i), .cnt_o(cnt_o),
		.ch_val_o(ch_val_o), .ovf_o(ovf_o), .hunf_o(hunf_o), .err_o(err_o),
		.cc_irq_o(cc_irq_o), .wg_o(wg_o), .pin_o(pin_o), .pin_ovr_o(pin_ovr_o),
		.fault_o(fault_o), .hires_frac_o(hires_frac_o));

	tcwu_drv_model drv (.clk_i(clk_i), .srst_i(srst_i), .pin_i(pin_o), .ovr_i(pin_ovr_o),
		.trip_i(trip), .fault_evt_o(fault_evt), .shoot_cnt_o(shoot));

	// Free-running 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Inputs move 1 ns after the edge, outputs are settled then too
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Bounded wait for the wrap pulse; a hang ends the run
	task automatic wait_ovf(input int lim);
		for (int j = 0; j < lim; j++) begin
			tick();
			if (ovf_o === 1'b1)
				return;
		end
		bad_count++;
		$display("MISMATCH %0t overflow never came", $time);
		summarize();
	endtask

	task automatic wr_per(input logic [15:0] v);
		per_val_i = v;
		per_wr_i  = 1'b1;
		tick();
		per_wr_i  = 1'b0;
	endtask

	task automatic wr_cc(input int ch, input logic [15:0] v);
		cc_val_i = v;
		cc_wr_i  = 4'h1 << ch;
		tick();
		cc_wr_i  = 4'h0;
	endtask

	// Next count for a counter of period p
	function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] p,
		input logic dn);
		if (dn)
			return (c == 16'h0000) ? p : c - 16'h0001;
		return (c == p) ? 16'h0000 : c + 16'h0001;
	endfunction

	initial begin
		cfg_i = '{tcwu_pkg::CS_PER, 4'h0, 1'b0, tcwu_pkg::WG_SS, 1'b0, tcwu_pkg::CP_IN, 1'b0, 2'h0};
		advanced_waveform_extension_i = '0;
		{per_wr_i, dt_wr_i, pat_wr_i, cnt_evt_i, fault_clr_i, trip} = '0;
		{per_val_i, cc_val_i, cc_wr_i, dt_ls_i, dt_hs_i, pat_i} = '0;
		srst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		#1 srst_i = 1'b0;
		`CHK(cnt_o, 16'h0000)
		`CHK({ovf_o, fault_o, pin_o}, 10'h000)
		// Period write waits in the buffer until the wrap
		wr_per(16'h0002);
		for (i = 0; i < 10 && cnt_o !== 16'h0003; i++) tick();
		`CHK(cnt_o, 16'h0003)
		wait_ovf(70000);
		`CHK(cnt_o, 16'h0000)
		for (k = 1; k <= 3; k++) begin
			tick();
			`CHK(cnt_o, 16'(k % 3))
			`CHK(ovf_o, k == 3)
		end
		$display("test buffered period done");
		// Wrap spacing scales with the prescaler
		for (k = 0; k < 4; k++) begin
			cfg_i.presc = 4'(k);
			wait_ovf(200);
			wait_ovf(200);
			n = 0;
			while (n < 200 && ovf_o !== 1'b1 || n == 0) begin
				tick();
				n++;
			end
			`CHK(n, 3 << k)
		end
		cfg_i.presc = 4'h0;
		$display("test prescaler done");
		// Stopped clock, then random event counting
		cfg_i.clk_sel = tcwu_pkg::CS_OFF;
		tick();
		c0 = cnt_o;
		repeat (20) tick();
		`CHK(cnt_o, c0)
		cfg_i.clk_sel = tcwu_pkg::CS_EVT;
		tick();
		c0 = cnt_o;
		n = 1 + ($unsigned($random(seed)) % 8);
		for (k = 0; k < n; k++) begin
			cnt_evt_i = 1'b1;
			tick();
			cnt_evt_i = 1'b0;
			tick();
			c0 = nxt(c0, 16'h0002, 1'b0);
		end
		`CHK(cnt_o, c0)
		$display("test event count done");
		// Down counting, normal and split (low byte always down)
		cfg_i.clk_sel = tcwu_pkg::CS_PER;
		for (k = 0; k < 2; k++) begin
			cfg_i.dir_down = (k == 0);
			cfg_i.split = (k == 1);
			repeat (4) tick();
			for (i = 0; i < 6; i++) begin
				c0 = nxt({8'h00, cnt_o[7:0]}, 16'h0002, 1'b1);
				tick();
				`CHK(cnt_o[7:0], c0[7:0])
				if (k == 1) `CHK(hunf_o, 1'b1)
			end
		end
		{cfg_i.dir_down, cfg_i.split} = 2'b00;
		$display("test down and split done");
		// Every channel matches at its random compare value
		wr_per(16'h0007);
		for (k = 0; k < 4; k++) begin
			cmp[k] = 16'($unsigned($random(seed)) % 7);
			wr_cc(k, cmp[k]);
		end
		wait_ovf(70000);
		for (k = 0; k < 4; k++) begin
			for (i = 0; i < 20 && cc_irq_o[k] !== 1'b1; i++) tick();
			`CHK(cnt_o, cmp[k] + 16'h0001)
			`CHK(ch_val_o[k], cmp[k])
			`CHK(wg_o[k], 1'b0)
		end
		$display("test compare match done");
		// Pattern generator takes the pins after the wrap
		pat_i = tcwu_pkg::tcwu_pat_s'(16'($random(seed)));
		advanced_waveform_extension_i.pg_en = 1'b1;
		pat_wr_i = 1'b1;
		tick();
		pat_wr_i = 1'b0;
		wait_ovf(100);
		repeat (3) tick();
		`CHK(pin_ovr_o, pat_i.mask)
		`CHK(pin_o & pat_i.mask, pat_i.value & pat_i.mask)
		// Fault kills pins next edge and holds until a clean clear
		trip = 1'b1;
		tick();
		trip = 1'b0;
		`CHK({fault_o, pin_o}, 9'h100)
		repeat (5) tick();
		{trip, fault_clr_i} = 2'b11;
		tick();
		trip = 1'b0;
		`CHK(fault_o, 1'b1)
		tick();
		fault_clr_i = 1'b0;
		`CHK(fault_o, 1'b0)
		$display("test pattern and fault done");
		// Dead time keeps both legs apart while each still switches
		advanced_waveform_extension_i = '{1'b1, 1'b0, 1'b0, 1'b0, 8'hFF};
		wr_cc(0, 16'h0004);
		dt_ls_i = 8'(1 + $unsigned($random(seed)) % 2);
		dt_hs_i = 8'(1 + $unsigned($random(seed)) % 2);
		dt_wr_i = 1'b1;
		tick();
		dt_wr_i = 1'b0;
		wait_ovf(100);
		wait_ovf(100);
		seen = 8'h00;
		repeat (60) begin
			tick();
			seen = seen | pin_o;
		end
		`CHK(seen[1:0], 2'b11)
		`CHK(shoot, 0)
		$display("test dead time done");
		summarize();
	end
endmodule
